/* File: rtl/svpc_top.sv */
`timescale 1ns/1ps
module svpc_top
	import svpc_pkg::*;
#(
	parameter int PHASES = 4
)(
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels.
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels.
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pins from the host and the board.
	input wire logic serial_vid_clock_pin,
	input wire logic serial_vid_data_pin,
	input wire logic host_power_ok,
	input wire logic enable_pin,
	input wire logic vout_in_window,
	// PWM modulator high pulses, one per channel, same clock.
	input wire logic [PHASES-1:0] pwm_high,
	// Regulator control outputs.
	output logic output_power_good,
	output logic [6:0] core_ref_code,
	output logic [6:0] bridge_ref_code,
	output logic core_plane_off,
	output logic bridge_plane_off,
	output logic [7:0] core_offset_code,
	output logic [PHASES-1:0] phase_tristate,
	output logic power_save_active
);
	logic [2:0] meta, sync; // Pin synchronisers: host ok, enable, window.
	logic [1:0] pin_meta, pin_sync; // Boot strap pin synchroniser.
	logic en_prev; // Enable level one cycle ago.
	logic ok_s, en_s, win_s;
	logic [31:0] ctrl; // Control register.
	svpc_seq_t seq; // Power sequencer state.
	svpc_ph_t ph; // Phase shedding state.
	logic [6:0] boot_code; // Holding register for the start-up level.
	logic [6:0] core_tgt, bridge_tgt; // Reference targets.
	logic [6:0] pend_core, pend_bridge; // Command awaiting application.
	logic pend_valid, pend_chg, want_save;
	logic core_off_tgt, bridge_off_tgt;
	logic [8:0] step_cnt; // Slew tick divider.
	logic settled;
	logic cmd_valid, cmd_core, cmd_bridge;
	logic [7:0] cmd_data;
	logic [2:0] wait_cnt; // PWM cycles left before the next phase change.
	logic [PHASES-1:0] victim, act, shed_cand;
	logic save_req, delay0;
	logic blk; // Later channels wait until this one switches.
	logic [2:0] delay_cycles;
	logic aw_held, w_held;
	logic [3:0] aw_addr;

	// Two flip-flops for every asynchronous input.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta <= 3'h0;
			sync <= 3'h0;
			pin_meta <= 2'h0;
			pin_sync <= 2'h0;
			en_prev <= 1'b0;
		end else begin
			meta <= {host_power_ok, enable_pin, vout_in_window};
			sync <= meta;
			pin_meta <= {serial_vid_clock_pin, serial_vid_data_pin};
			pin_sync <= pin_meta;
			en_prev <= sync[1];
		end
	end
	assign ok_s = sync[2];
	assign en_s = sync[1];
	assign win_s = sync[0];

	// Serial receiver listens only while the host has signalled ok.
	svpc_svi_rx u_rx (
		.aclk(aclk),
		.aresetn(aresetn),
		.svc_pin(serial_vid_clock_pin),
		.svd_pin(serial_vid_data_pin),
		.listen(seq == SVPC_S_RUN && ok_s),
		.cmd_valid(cmd_valid),
		.cmd_core(cmd_core),
		.cmd_bridge(cmd_bridge),
		.cmd_data(cmd_data)
	);

	// Start-up level captured when enable rises.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			boot_code <= SVPC_BOOT_00;
		end else if (en_s && !en_prev) begin
			unique case (pin_sync)
				2'h0: boot_code <= SVPC_BOOT_00;
				2'h1: boot_code <= SVPC_BOOT_01;
				2'h2: boot_code <= SVPC_BOOT_10;
				2'h3: boot_code <= SVPC_BOOT_11;
			endcase
		end
	end

	// Power sequencer, targets and pending command handling.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seq <= SVPC_S_OFF;
			core_tgt <= SVPC_CODE_ZERO;
			bridge_tgt <= SVPC_CODE_ZERO;
			core_off_tgt <= 1'b0;
			bridge_off_tgt <= 1'b0;
			pend_core <= SVPC_CODE_ZERO;
			pend_bridge <= SVPC_CODE_ZERO;
			pend_valid <= 1'b0;
			pend_chg <= 1'b0;
			want_save <= 1'b0;
			output_power_good <= 1'b0;
		end else begin
			unique case (seq)
				SVPC_S_OFF: begin
					if (en_s && !en_prev) begin
						seq <= SVPC_S_SOFT;
					end
				end
				SVPC_S_SOFT: begin
					// The latched boot level becomes the target one cycle after capture.
					core_tgt <= boot_code;
					bridge_tgt <= boot_code;
					if (!en_s) begin
						seq <= SVPC_S_DOWN;
					end else if (settled && core_tgt == boot_code && win_s) begin
						output_power_good <= 1'b1;
						seq <= SVPC_S_RUN;
					end
				end
				SVPC_S_RUN, SVPC_S_BOOT: begin
					if (!en_s || !win_s) begin
						// Enable or regulation lost: ramp down in code steps.
						output_power_good <= 1'b0;
						core_tgt <= SVPC_CODE_ZERO;
						bridge_tgt <= SVPC_CODE_ZERO;
						pend_valid <= 1'b0;
						want_save <= 1'b0;
						seq <= SVPC_S_DOWN;
					end else if (!ok_s) begin
						// Back to the held start-up level for both planes.
						core_tgt <= boot_code;
						bridge_tgt <= boot_code;
						core_off_tgt <= 1'b0;
						bridge_off_tgt <= 1'b0;
						pend_valid <= 1'b0;
						want_save <= 1'b0;
						seq <= SVPC_S_BOOT;
					end else if (seq == SVPC_S_BOOT) begin
						seq <= SVPC_S_RUN;
					end else if (cmd_valid) begin
						// Accepted only with power good and host ok.
						pend_core <= cmd_core ? cmd_data[6:0] : core_tgt;
						pend_bridge <= cmd_bridge ? cmd_data[6:0] : bridge_tgt;
						pend_chg <= (cmd_core && cmd_data[6:0] != core_tgt)
							|| (cmd_bridge && cmd_data[6:0] != bridge_tgt);
						pend_valid <= 1'b1;
						want_save <= !cmd_data[SVPC_PSI_BIT];
					end else if (pend_valid && (!pend_chg || ph == SVPC_P_FULL)) begin
						// A level change waits for full phases first.
						pend_valid <= 1'b0;
						// Off codes ramp to near zero and flag the plane off.
						core_off_tgt <= pend_core >= SVPC_CODE_OFF;
						bridge_off_tgt <= pend_bridge >= SVPC_CODE_OFF;
						core_tgt <= pend_core >= SVPC_CODE_OFF ? SVPC_CODE_ZERO : pend_core;
						bridge_tgt <= pend_bridge >= SVPC_CODE_OFF ? SVPC_CODE_ZERO : pend_bridge;
					end
					// Core off leaves power good as it is.
				end
				SVPC_S_DOWN: begin
					output_power_good <= 1'b0;
					core_tgt <= SVPC_CODE_ZERO;
					bridge_tgt <= SVPC_CODE_ZERO;
					if (en_s && !en_prev) begin
						seq <= SVPC_S_SOFT;
					end
				end
				default: seq <= SVPC_S_OFF;
			endcase
		end
	end

	// References move one code per slew tick toward their targets.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			step_cnt <= 9'h000;
			core_ref_code <= SVPC_CODE_ZERO;
			bridge_ref_code <= SVPC_CODE_ZERO;
			core_plane_off <= 1'b1;
			bridge_plane_off <= 1'b1;
		end else begin
			step_cnt <= (step_cnt == 9'(SVPC_STEP_CYCLES - 1)) ? 9'h000 : step_cnt + 9'h001;
			if (step_cnt == 9'h000) begin
				if (core_ref_code < core_tgt) core_ref_code <= core_ref_code + 7'h01;
				else if (core_ref_code > core_tgt) core_ref_code <= core_ref_code - 7'h01;
				if (bridge_ref_code < bridge_tgt) bridge_ref_code <= bridge_ref_code + 7'h01;
				else if (bridge_ref_code > bridge_tgt) bridge_ref_code <= bridge_ref_code - 7'h01;
			end
			// Plane off once flagged off and both references have reached their targets.
			core_plane_off <= (seq == SVPC_S_OFF) || (core_off_tgt && settled);
			bridge_plane_off <= (seq == SVPC_S_OFF) || (bridge_off_tgt && settled);
		end
	end
	assign settled = core_ref_code == core_tgt && bridge_ref_code == bridge_tgt;

	// Phase selection: keep the lowest channels, shed from the top.
	always_comb begin
		shed_cand = '0;
		victim = '0;
		blk = 1'b0;
		for (int i = 0; i < PHASES; i++) begin
			shed_cand[i] = (i >= int'(ctrl[SVPC_F_PHASES +: 2]));
		end
		// With zero spacing a channel may follow at once once the one before it switches.
		if (ph == SVPC_P_SHED) begin
			for (int i = PHASES - 1; i >= 0; i--) begin
				if (!blk && shed_cand[i] && !phase_tristate[i]) begin
					victim[i] = 1'b1;
					blk = !delay0 || !pwm_high[i];
				end
			end
		end else if (ph == SVPC_P_REACT) begin
			for (int i = 0; i < PHASES; i++) begin
				if (!blk && phase_tristate[i]) begin
					victim[i] = 1'b1;
					blk = !delay0 || !pwm_high[i];
				end
			end
		end
		if (wait_cnt != 3'h0) victim = '0;
	end
	assign save_req = want_save && !(pend_valid && pend_chg) && settled && seq == SVPC_S_RUN;
	assign delay_cycles = ctrl[(ph == SVPC_P_REACT ? SVPC_F_REACT : SVPC_F_SHED) +: 2] == 2'h3
		? 3'h4 : {1'b0, ctrl[(ph == SVPC_P_REACT ? SVPC_F_REACT : SVPC_F_SHED) +: 2]};
	assign delay0 = delay_cycles == 3'h0;
	assign act = victim & pwm_high;

	// Each channel switches its tri-state only on its own PWM high.
	genvar g;
	generate
		for (g = 0; g < PHASES; g++) begin : g_phase
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					phase_tristate[g] <= 1'b0;
				end else if (act[g]) begin
					phase_tristate[g] <= (ph == SVPC_P_SHED);
				end
			end
		end
	endgenerate

	// Phase state and the PWM cycle spacing counter.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ph <= SVPC_P_FULL;
			wait_cnt <= 3'h0;
			power_save_active <= 1'b0;
		end else begin
			if (wait_cnt != 3'h0 && pwm_high[0]) begin
				wait_cnt <= wait_cnt - 3'h1;
			end else if (act != '0 && (victim & ~act) == '0) begin
				wait_cnt <= delay_cycles;
			end
			unique case (ph)
				SVPC_P_FULL: begin
					if (save_req && (shed_cand & ~phase_tristate) != '0) ph <= SVPC_P_SHED;
				end
				SVPC_P_SHED: begin
					if (!save_req) ph <= SVPC_P_REACT;
					else if (wait_cnt == 3'h0 && victim == '0) ph <= SVPC_P_SAVE;
				end
				SVPC_P_SAVE: begin
					if (!save_req) ph <= SVPC_P_REACT;
				end
				SVPC_P_REACT: begin
					if (save_req) ph <= SVPC_P_SHED;
					else if (wait_cnt == 3'h0 && phase_tristate == '0) ph <= SVPC_P_FULL;
				end
				default: ph <= SVPC_P_FULL;
			endcase
			power_save_active <= (ph == SVPC_P_SAVE);
		end
	end

	// Core offset follows the register unless dropped during power saving.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_offset_code <= 8'h00;
		end else if (power_save_active && ctrl[SVPC_F_DROP]) begin
			core_offset_code <= 8'h00;
		end else begin
			core_offset_code <= ctrl[SVPC_F_OFFS +: 8];
		end
	end

	// AXI4-Lite write: address and data taken in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			ctrl <= SVPC_CTRL_RST;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) w_held <= 1'b1;
			if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
			if (aw_held && w_held && !s_axi_bvalid) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr == SVPC_CTRL_OFF) ? 2'h0 : 2'h3;
				if (aw_addr == SVPC_CTRL_OFF) begin
					for (int b = 0; b < 2; b++) begin
						if (s_axi_wstrb[b]) ctrl[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
					end
				end
			end
		end
	end
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;

	// AXI4-Lite read: data one cycle after the address is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			s_axi_rdata <= 32'h0000_0000;
			if (s_axi_araddr == SVPC_CTRL_OFF) begin
				s_axi_rdata <= {16'h0000, ctrl[15:0]};
			end else if (s_axi_araddr == SVPC_STAT_OFF) begin
				s_axi_rdata[SVPC_F_CORE +: 7] <= core_ref_code;
				s_axi_rdata[SVPC_F_BRIDGE +: 7] <= bridge_ref_code;
				s_axi_rdata[SVPC_F_TRI +: PHASES] <= phase_tristate;
				s_axi_rdata[SVPC_F_PGOOD] <= output_power_good;
				s_axi_rdata[SVPC_F_PSAVE] <= power_save_active;
			end else begin
				s_axi_rresp <= 2'h3;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	assign s_axi_arready = !s_axi_rvalid;
endmodule

/* File: rtl/svpc_pkg.sv */
package svpc_pkg;
	// Register byte offsets.
	localparam logic [3:0] SVPC_CTRL_OFF = 4'h0;
	localparam logic [3:0] SVPC_STAT_OFF = 4'h4;
	// Control register fields and reset value.
	localparam int SVPC_F_PHASES = 0;
	localparam int SVPC_F_SHED = 2;
	localparam int SVPC_F_REACT = 4;
	localparam int SVPC_F_DROP = 6;
	localparam int SVPC_F_OFFS = 8;
	localparam logic [31:0] SVPC_CTRL_RST = 32'h0000_0016;
	// Status register fields.
	localparam int SVPC_F_CORE = 0;
	localparam int SVPC_F_BRIDGE = 8;
	localparam int SVPC_F_TRI = 16;
	localparam int SVPC_F_PGOOD = 20;
	localparam int SVPC_F_PSAVE = 21;
	// Voltage codes: one code is 12.5 mV below the one before.
	localparam logic [6:0] SVPC_CODE_OFF = 7'h7C;
	localparam logic [6:0] SVPC_CODE_ZERO = 7'h7B;
	localparam logic [6:0] SVPC_BOOT_00 = 7'h24;
	localparam logic [6:0] SVPC_BOOT_01 = 7'h2C;
	localparam logic [6:0] SVPC_BOOT_10 = 7'h34;
	localparam logic [6:0] SVPC_BOOT_11 = 7'h3C;
	// Serial frame layout.
	localparam int SVPC_ADDR_CORE = 2;
	localparam int SVPC_ADDR_BRIDGE = 1;
	localparam int SVPC_FRAME_BITS = 18;
	localparam int SVPC_PSI_BIT = 7;
	// Reference slew timing.
	localparam int SVPC_CLK_NS = 10;
	localparam int SVPC_STEP_UV = 12500;
	localparam int SVPC_SLEW_UV_PER_US = 3250;
	localparam int SVPC_STEP_CYCLES = (SVPC_STEP_UV * 1000 + SVPC_SLEW_UV_PER_US * SVPC_CLK_NS - 1)
		/ (SVPC_SLEW_UV_PER_US * SVPC_CLK_NS);
	// Sequencer and phase states.
	typedef enum logic [2:0] {SVPC_S_OFF, SVPC_S_SOFT, SVPC_S_RUN, SVPC_S_BOOT, SVPC_S_DOWN}
		svpc_seq_t;
	typedef enum logic [2:0] {SVPC_P_FULL, SVPC_P_SHED, SVPC_P_SAVE, SVPC_P_REACT} svpc_ph_t;
endpackage

/* File: rtl/svpc_svi_rx.sv */
`timescale 1ns/1ps
module svpc_svi_rx
	import svpc_pkg::*;
(
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Raw serial pins and gate.
	input wire logic svc_pin,
	input wire logic svd_pin,
	input wire logic listen,
	// Decoded command, one-cycle pulse.
	output logic cmd_valid,
	output logic cmd_core,
	output logic cmd_bridge,
	output logic [7:0] cmd_data
);
	logic [1:0] meta; // First synchroniser stage.
	logic [1:0] sync; // Second stage, {clock, data}.
	logic [1:0] prev; // Previous synchronised levels for edge finding.
	logic [4:0] nbits; // Bits received since the start condition.
	logic [17:0] shreg; // Frame shift register.
	logic busy; // A frame is in progress.
	logic rise_c, start_c, stop_c;

	// Two flip-flops per pin before any logic looks at it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta <= 2'h3;
			sync <= 2'h3;
			prev <= 2'h3;
		end else begin
			meta <= {svc_pin, svd_pin};
			sync <= meta;
			prev <= sync;
		end
	end

	assign rise_c = sync[1] && !prev[1];
	assign start_c = sync[1] && prev[1] && prev[0] && !sync[0];
	assign stop_c = sync[1] && prev[1] && !prev[0] && sync[0];

	// Shift bits on clock rise; frame ends at the stop condition.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 1'b0;
			nbits <= 5'h00;
			shreg <= 18'h00000;
			cmd_valid <= 1'b0;
			cmd_core <= 1'b0;
			cmd_bridge <= 1'b0;
			cmd_data <= 8'h00;
		end else begin
			cmd_valid <= 1'b0;
			if (!listen) begin
				busy <= 1'b0;
			end else if (start_c) begin
				busy <= 1'b1;
				nbits <= 5'h00;
			end else if (stop_c && busy) begin
				busy <= 1'b0;
				// Address byte selects planes, data byte carries code and power-save flag.
				// The stop condition brings one more clock rise after the last bit.
				if (nbits == 5'(SVPC_FRAME_BITS + 1)) begin
					cmd_valid <= shreg[10 + SVPC_ADDR_CORE] || shreg[10 + SVPC_ADDR_BRIDGE];
					cmd_core <= shreg[10 + SVPC_ADDR_CORE];
					cmd_bridge <= shreg[10 + SVPC_ADDR_BRIDGE];
					cmd_data <= shreg[8:1];
				end
			end else if (busy && rise_c && nbits != 5'h1F) begin
				// Only frame bits enter the shift register.
				if (nbits < 5'(SVPC_FRAME_BITS)) shreg <= {shreg[16:0], sync[0]};
				nbits <= nbits + 5'h01;
			end
		end
	end
endmodule

/* File: sim/svpc_chk_sva.sv */
`timescale 1ns/1ps
// Watches the phase and reference outputs of the top module.
module svpc_chk
	import svpc_pkg::*;
#(
	parameter int PHASES = 4
)(
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Modulator pulses.
	input wire logic [PHASES-1:0] pwm_high,
	// Regulator control outputs.
	input wire logic output_power_good,
	input wire logic [6:0] core_ref_code,
	input wire logic [6:0] bridge_ref_code,
	input wire logic core_plane_off,
	input wire logic bridge_plane_off,
	input wire logic [PHASES-1:0] phase_tristate
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Channels still switching; shedding from the top leaves a low mask.
	logic [PHASES-1:0] live;
	// Cycles since the core reference last moved, saturating.
	logic [9:0] gap;
	// Core reference one cycle earlier.
	logic [6:0] prev_core;
	assign live = ~phase_tristate;
	// Measures the time between core reference steps.
	always_ff @(posedge aclk) begin
		prev_core <= core_ref_code;
		if (!aresetn || core_ref_code != prev_core) begin
			gap <= 10'h000;
		end else if (gap != 10'h3FF) begin
			gap <= gap + 10'h001;
		end
	end
	shed_at_pwm_a: assert property (
		(phase_tristate & ~$past(phase_tristate) & ~$past(pwm_high)) == '0)
		else $error("phase tri-stated without its pwm pulse");
	react_at_pwm_a: assert property (output_power_good && $past(output_power_good) |->
		(~phase_tristate & $past(phase_tristate) & ~$past(pwm_high)) == '0)
		else $error("phase left tri-state without its pwm pulse");
	shed_order_a: assert property ((live & (live + 1'b1)) == '0)
		else $error("shed channels are not the highest ones");
	ref_step_a: assert property (core_ref_code != $past(core_ref_code) |->
		core_ref_code == $past(core_ref_code) + 7'h01 ||
		core_ref_code == $past(core_ref_code) - 7'h01)
		else $error("core reference jumped more than one code");
	step_gap_a: assert property (output_power_good && core_ref_code != prev_core |->
		gap >= 10'h17C)
		else $error("core reference stepped too soon");
	core_off_a: assert property ($rose(core_plane_off) |->
		output_power_good && !bridge_plane_off)
		else $error("core off lost power good or bridge");
	core_zero_a: assert property (core_plane_off |-> core_ref_code == SVPC_CODE_ZERO)
		else $error("core off with reference above zero");
	bridge_zero_a: assert property (bridge_plane_off |-> bridge_ref_code == SVPC_CODE_ZERO)
		else $error("bridge off with reference above zero");
	loss_ramp_a: assert property ($fell(output_power_good) |-> ##[1:800]
		(bridge_ref_code == SVPC_CODE_ZERO || bridge_ref_code > $past(bridge_ref_code)))
		else $error("bridge reference not ramping down after power good loss");
	shed_c: cover property ($rose(|phase_tristate));
	off_c: cover property ($rose(core_plane_off));
	loss_c: cover property ($fell(output_power_good));
endmodule

bind svpc_top svpc_chk #(.PHASES(PHASES)) i_svpc_chk (
	.aclk, .aresetn, .pwm_high, .output_power_good, .core_ref_code, .bridge_ref_code,
	.core_plane_off, .bridge_plane_off, .phase_tristate
);

/* File: sim/svpc_host.sv */
`timescale 1ns/1ps
// Host end of the serial link; both lines idle high as their pull-ups leave them.
module svpc_host (
	// Link lines.
	output logic serial_vid_clock_pin,
	output logic serial_vid_data_pin
);
	// The link clock stands still high between frames.
	initial begin
		serial_vid_clock_pin = 1'b1;
		serial_vid_data_pin = 1'b1;
	end
	// Sends one frame; frame bits change only while the clock is low, start and stop while it is high.
	task automatic send_frame(input logic [7:0] addr, input logic [7:0] data);
		logic [17:0] bits;
		bits = {addr, 1'b1, data, 1'b1};
		serial_vid_data_pin = 1'b0;
		#80;
		for (int i = 17; i >= 0; i--) begin
			serial_vid_clock_pin = 1'b0;
			#40;
			serial_vid_data_pin = bits[i];
			#40;
			serial_vid_clock_pin = 1'b1;
			#80;
		end
		serial_vid_clock_pin = 1'b0;
		#40;
		serial_vid_data_pin = 1'b0;
		#40;
		serial_vid_clock_pin = 1'b1;
		#40;
		serial_vid_data_pin = 1'b1;
		#80;
	endtask
endmodule

/* File: sim/serial_vid_phase_shed_control_tb.sv */
`timescale 1ns/1ps
// Runs start-up, commands, shedding and power-down through the control block.
module serial_vid_phase_shed_control_tb
	import svpc_pkg::*;
;
	localparam logic [7:0] CORE = 8'h01 << SVPC_ADDR_CORE;
	localparam logic [7:0] BRIDGE = 8'h01 << SVPC_ADDR_BRIDGE;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	// Bus master side.
	logic [3:0] s_axi_awaddr = 4'h0;
	logic [3:0] s_axi_araddr = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, rd;
	// Pins, board status and modulator pulses.
	logic serial_vid_clock_pin, serial_vid_data_pin;
	logic host_power_ok = 1'b0;
	logic enable_pin = 1'b0;
	logic vout_in_window = 1'b1;
	logic [3:0] pwm_high = 4'h0;
	logic [2:0] pwm_cnt = 3'h0;
	// Control outputs.
	logic output_power_good, core_plane_off, bridge_plane_off, power_save_active;
	logic [6:0] core_ref_code, bridge_ref_code;
	logic [7:0] core_offset_code;
	logic [3:0] phase_tristate;
	int fail_count = 0;
	int cmp_count = 0;
	int waited;
	initial begin
		forever #5 aclk = ~aclk;
	end
	// Channel 0 pulses last in each period, so spacing shows up as delay.
	always @(posedge aclk) begin
		pwm_cnt <= pwm_cnt + 3'h1;
		for (int i = 0; i < 4; i++) begin
			pwm_high[i] <= (pwm_cnt == 3'(7 - 2 * i));
		end
	end
	svpc_top #(.PHASES(4)) i_svpc_top (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_vid_clock_pin,
		.serial_vid_data_pin, .host_power_ok, .enable_pin, .vout_in_window, .pwm_high,
		.output_power_good, .core_ref_code, .bridge_ref_code, .core_plane_off,
		.bridge_plane_off, .core_offset_code, .phase_tristate, .power_save_active
	);
	svpc_host i_svpc_host (.serial_vid_clock_pin, .serial_vid_data_pin);
	// Compares one observed value with its expected value.
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Picks one observed output by number.
	function automatic logic [31:0] cur(input int sel);
		case (sel)
			0: return {25'h0, core_ref_code};
			1: return {25'h0, bridge_ref_code};
			2: return {28'h0, phase_tristate};
			3: return {31'h0, output_power_good};
			default: return {31'h0, core_plane_off};
		endcase
	endfunction
	// Waits a bounded time for an output to reach a value, then compares it.
	task automatic wait_chk(input string nm, input int sel, input logic [31:0] exp, input int lim);
		waited = 0;
		while (cur(sel) !== exp && waited < lim) begin
			@(posedge aclk);
			waited++;
		end
		chk(nm, exp, cur(sel));
	endtask
	// Writes one register word; both channels are offered together.
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 100);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// Reads one register word.
	task automatic axi_rd(input logic [3:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 100);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// Reset levels, control reset value and unmapped places.
	task automatic t_reset();
		chk("reset good", 32'h0, cur(3));
		chk("reset ref", 32'h7B, cur(0));
		chk("reset off", 32'h1, cur(4));
		axi_rd(SVPC_CTRL_OFF);
		chk("ctrl reset", SVPC_CTRL_RST, rd);
		axi_rd(4'h8);
		chk("unmapped rd", 32'h3, {30'h0, rsp});
		axi_wr(4'hC, 32'h0);
		chk("unmapped wr", 32'h3, {30'h0, rsp});
		$display("done: reset");
	endtask
	// Start-up to the latched boot level; frames before host ok do nothing.
	task automatic t_boot();
		@(posedge aclk);
		enable_pin <= 1'b1;
		wait_chk("power good", 3, 32'h1, 40000);
		chk("boot core", {25'h0, SVPC_BOOT_11}, cur(0));
		chk("boot bridge", {25'h0, SVPC_BOOT_11}, cur(1));
		i_svpc_host.send_frame(CORE, 8'hB0);
		repeat (1000) @(posedge aclk);
		chk("early frame", 32'h3C, cur(0));
		$display("done: boot");
	endtask
	// Plane addressing of set-voltage commands.
	task automatic t_cmd();
		@(posedge aclk);
		host_power_ok <= 1'b1;
		repeat (8) @(posedge aclk);
		i_svpc_host.send_frame(CORE, 8'hB8);
		wait_chk("core step", 0, 32'h38, 3000);
		chk("bridge kept", 32'h3C, cur(1));
		i_svpc_host.send_frame(BRIDGE, 8'hBB);
		wait_chk("bridge step", 1, 32'h3B, 1500);
		$display("done: command");
	endtask
	// Shed to two phases, one PWM cycle apart, offset dropped, then back.
	task automatic t_shed();
		axi_wr(SVPC_CTRL_OFF, 32'h0000_0556);
		repeat (4) @(posedge aclk);
		chk("offset on", 32'h5, {24'h0, core_offset_code});
		i_svpc_host.send_frame(CORE, 8'h38);
		wait_chk("first shed", 2, 32'h8, 2000);
		wait_chk("second shed", 2, 32'hC, 200);
		chk("shed spacing", 32'h1, {31'h0, waited >= 8});
		repeat (12) @(posedge aclk);
		chk("saving", 32'h1, {31'h0, power_save_active});
		chk("offset dropped", 32'h0, {24'h0, core_offset_code});
		repeat (100) @(posedge aclk);
		chk("two kept", 32'hC, cur(2));
		i_svpc_host.send_frame(CORE, 8'hB8);
		wait_chk("first back", 2, 32'h8, 2000);
		wait_chk("all back", 2, 32'h0, 200);
		repeat (4) @(posedge aclk);
		chk("offset back", 32'h5, {24'h0, core_offset_code});
		$display("done: shed");
	endtask
	// Zero spacing sheds down to one phase within one PWM period.
	task automatic t_zero();
		axi_wr(SVPC_CTRL_OFF, 32'h0000_0011);
		i_svpc_host.send_frame(CORE, 8'h38);
		wait_chk("zero first", 2, 32'h8, 2000);
		wait_chk("zero all", 2, 32'hE, 30);
		chk("zero spacing", 32'h1, {31'h0, waited <= 7});
		i_svpc_host.send_frame(CORE, 8'hB8);
		wait_chk("zero back", 2, 32'h0, 2000);
		$display("done: zero");
	endtask
	// Host ok low returns to boot level; after it returns, targets hold.
	task automatic t_hostok();
		@(posedge aclk);
		host_power_ok <= 1'b0;
		i_svpc_host.send_frame(CORE, 8'hB0);
		wait_chk("core boot", 0, 32'h3C, 3000);
		wait_chk("bridge boot", 1, 32'h3C, 1000);
		@(posedge aclk);
		host_power_ok <= 1'b1;
		repeat (2000) @(posedge aclk);
		chk("hold", 32'h3C, cur(0));
		$display("done: host ok");
	endtask
	// Core off keeps power good and the bridge plane.
	task automatic t_coreoff();
		i_svpc_host.send_frame(CORE, 8'hFC);
		wait_chk("core off", 4, 32'h1, 30000);
		chk("good kept", 32'h1, cur(3));
		chk("bridge on", 32'h0, {31'h0, bridge_plane_off});
		$display("done: core off");
	endtask
	// Losing regulation ramps the references down.
	task automatic t_pgood();
		@(posedge aclk);
		vout_in_window <= 1'b0;
		wait_chk("good lost", 3, 32'h0, 100);
		wait_chk("bridge down", 1, 32'h7B, 30000);
		$display("done: power good loss");
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Main sequence.
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_boot();
		t_cmd();
		t_shed();
		t_zero();
		t_hostok();
		t_coreoff();
		t_pgood();
		finish_test();
	end
	// The tests take about 80000 cycles; this cuts a hang short.
	initial begin
		#990us;
		fail_count++;
		finish_test();
	end
endmodule
